// >>> shbp_port16.sv
// Synchronous 16-bit host bus port, device end
`timescale 1ns/1ps
`default_nettype none
`include "shbp_cfg.svh"
module shbp_port16 #(
   parameter int DATA_W = `SHBP_DATA_BITS,
   parameter int ADDR_W = `SHBP_ADDR_BITS
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic chip_select_n,
   input wire logic mem_reg_select,
   input wire logic [ADDR_W-1:0] device_address,
   input wire logic low_byte_read_n,
   input wire logic high_byte_read_n,
   input wire logic low_byte_write_n,
   input wire logic high_byte_write_n,
   input wire logic bus_start_n,
   input wire logic [DATA_W-1:0] dataIn,
   output logic [DATA_W-1:0] dataOut,
   output logic dataOutEn_n,
   output logic hold_off_n,
   output logic holdOffEn_n,
   input wire logic endian_strap,
   input wire logic hold_polarity_strap,
   input wire logic [2:0] modeStrap,
   output logic [3:0] busMode,
   output logic bigEndian,
   output logic reqValid,
   output shbp_pkg::shbp_req_s reqOut,
   input wire logic rspReady,
   input wire logic [DATA_W-1:0] rspData
);
   // ------------------------------------------------------------
   // Strap capture
   // ------------------------------------------------------------
   shbp_pkg::shbp_strap_s strapIn;
   shbp_pkg::shbp_strap_s strapNow;
   assign strapIn = '{busMode: {endian_strap, modeStrap}, holdActiveHigh: hold_polarity_strap};
   shbp_strap_latch uStrap (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .strapIn(strapIn),
      .strapOut(strapNow)
   );

   // ------------------------------------------------------------
   // Access decode
   // ------------------------------------------------------------
   logic anyRead;
   logic anyWrite;
   logic selActive;
   assign selActive = ~chip_select_n;
   assign anyRead = selActive & (~low_byte_read_n | ~high_byte_read_n);
   assign anyWrite = selActive & (~low_byte_write_n | ~high_byte_write_n);

   // ------------------------------------------------------------
   // Cycle state
   // ------------------------------------------------------------
   shbp_pkg::shbp_state_e state_reg;
   shbp_pkg::shbp_state_e state_next;
   shbp_pkg::shbp_req_s req_reg;
   shbp_pkg::shbp_req_s req_next;
   logic reqValid_reg;
   logic reqValid_next;
   logic [DATA_W-1:0] dataOut_reg;
   logic [DATA_W-1:0] dataOut_next;
   logic drive_reg;
   logic drive_next;
   logic holdAct_reg;
   logic holdAct_next;
   logic holdOut;

   always_comb begin
      state_next = state_reg;
      req_next = req_reg;
      reqValid_next = 1'b0;
      dataOut_next = dataOut_reg;
      drive_next = 1'b0;
      holdAct_next = 1'b0;
      unique case (state_reg)
         shbp_pkg::SHBP_IDLE: begin
            if (anyRead || anyWrite) begin
               req_next.memSpace = mem_reg_select;
               req_next.addr = device_address;
               req_next.isWrite = anyWrite;
               // Reads always move both bytes
               req_next.byteEn = anyWrite ? {~high_byte_write_n, ~low_byte_write_n} : 2'h3;
               req_next.wdata = dataIn;
               reqValid_next = 1'b1;
               state_next = shbp_pkg::SHBP_WAIT;
            end
         end
         shbp_pkg::SHBP_WAIT: begin
            // Stall until arbitration completes
            drive_next = ~req_reg.isWrite & selActive;
            if (!selActive) begin
               state_next = shbp_pkg::SHBP_IDLE;
            end else if (rspReady) begin
               dataOut_next = rspData;
               holdAct_next = 1'b1;
               state_next = shbp_pkg::SHBP_ACK;
            end
         end
         shbp_pkg::SHBP_ACK: begin
            // Acknowledge stands for exactly one clock
            drive_next = ~req_reg.isWrite & selActive;
            state_next = shbp_pkg::SHBP_DONE;
         end
         shbp_pkg::SHBP_DONE: begin
            // No burst stepping; each strobe is one single transfer
            // No error response is generated here
            drive_next = ~req_reg.isWrite & selActive;
            if (!(anyRead || anyWrite)) begin
               state_next = shbp_pkg::SHBP_IDLE;
            end
         end
      endcase
      if (!selActive) begin
         holdAct_next = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state_reg <= shbp_pkg::SHBP_IDLE;
         req_reg <= '0;
         reqValid_reg <= 1'b0;
         dataOut_reg <= '0;
         drive_reg <= 1'b0;
         holdAct_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         req_reg <= req_next;
         reqValid_reg <= reqValid_next;
         dataOut_reg <= dataOut_next;
         drive_reg <= drive_next;
         holdAct_reg <= holdAct_next;
      end
   end

   // ------------------------------------------------------------
   // Output registers
   // ------------------------------------------------------------
   logic holdPin_reg;
   logic holdEn_reg;
   logic dEn_reg;
   always_comb begin
      holdOut = strapNow.holdActiveHigh ? holdAct_next : ~holdAct_next;
   end
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         holdPin_reg <= 1'b0;
         holdEn_reg <= 1'b1;
         dEn_reg <= 1'b1;
      end else begin
         holdPin_reg <= holdOut;
         holdEn_reg <= ~selActive;
         dEn_reg <= ~drive_next;
      end
   end
   assign hold_off_n = holdPin_reg;
   assign holdOffEn_n = holdEn_reg;
   assign dataOut = dataOut_reg;
   assign dataOutEn_n = dEn_reg;
   assign reqValid = reqValid_reg;
   assign reqOut = req_reg;
   assign busMode = strapNow.busMode;
   assign bigEndian = strapNow.busMode[`SHBP_ENDIAN_BIT];

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_ack_one_cycle: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state_reg == shbp_pkg::SHBP_ACK |=> state_reg != shbp_pkg::SHBP_ACK)
      else $error("acknowledge longer than one cycle");
   chk_min_two_clocks: assert property (@(posedge clk_sys) disable iff (!reset_n)
      reqValid_reg |-> state_reg == shbp_pkg::SHBP_WAIT ##0 !holdAct_reg)
      else $error("cycle shorter than two clocks");
   chk_hold_idle_cs: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $past(chip_select_n) |-> holdEn_reg && !holdAct_reg)
      else $error("hold driven outside chip select");
   chk_read_full_word: assert property (@(posedge clk_sys) disable iff (!reset_n)
      reqValid_reg && !req_reg.isWrite |-> req_reg.byteEn == 2'h3)
      else $error("read not full width");
   chk_space_steer: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state_reg == shbp_pkg::SHBP_IDLE && (anyRead || anyWrite)
      |=> req_reg.memSpace == $past(mem_reg_select))
      else $error("space select not captured");
   chk_hold_until_ready: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state_reg == shbp_pkg::SHBP_WAIT && !rspReady |=> !holdAct_reg)
      else $error("acknowledge before ready");
   chk_ready_acks: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state_reg == shbp_pkg::SHBP_WAIT && rspReady && selActive
      |=> holdAct_reg ##1 !holdAct_reg)
      else $error("ready did not give one acknowledge");
   chk_strap_stable: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $past(reset_n) |-> $stable(strapNow))
      else $error("strap changed after reset");
   chk_single_only: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state_reg == shbp_pkg::SHBP_DONE && (anyRead || anyWrite) |=> !reqValid_reg)
      else $error("second transfer in same cycle");
endmodule // shbp_port16
`default_nettype wire

// >>> shbp_cfg.svh
// Constants for the synchronous host bus port
`ifndef SHBP_CFG_SVH
`define SHBP_CFG_SVH
`define SHBP_CLK_PERIOD_NS 10
`define SHBP_MIN_CYCLE_CLKS 2
`define SHBP_RSP_LATENCY 2
`define SHBP_REG_SPACE_BYTES 262144
`define SHBP_ADDR_BITS 18
`define SHBP_MODE_GENERIC1_BE 4'hb
`define SHBP_MODE_GENERIC2_LE 4'h4
`define SHBP_ENDIAN_BIT 3
`define SHBP_DATA_BITS 16
`endif

// >>> shbp_pkg.sv
// Types for the synchronous host bus port
package shbp_pkg;
   typedef enum logic [1:0] {
      SHBP_IDLE = 2'b00,
      SHBP_WAIT = 2'b01,
      SHBP_ACK = 2'b10,
      SHBP_DONE = 2'b11
   } shbp_state_e;
   typedef struct packed {
      logic memSpace;
      logic [17:0] addr;
      logic isWrite;
      logic [1:0] byteEn;
      logic [15:0] wdata;
   } shbp_req_s;
   typedef struct packed {
      logic [3:0] busMode;
      logic holdActiveHigh;
   } shbp_strap_s;
endpackage

// >>> shbp_strap_latch.sv
// Captures the configuration straps at reset release
`timescale 1ns/1ps
`default_nettype none
module shbp_strap_latch (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire shbp_pkg::shbp_strap_s strapIn,
   output var shbp_pkg::shbp_strap_s strapOut
);
   shbp_pkg::shbp_strap_s strap_reg;
   shbp_pkg::shbp_strap_s strap_next;
   always_comb begin
      strap_next = strap_reg;
      if (!reset_n) begin
         strap_next = strapIn;
      end
   end
   always_ff @(posedge clk_sys) begin
      strap_reg <= strap_next;
   end
   assign strapOut = strap_reg;
endmodule // shbp_strap_latch
`default_nettype wire

// >>> shbp_host_model.sv
// Host bus controller model with one chip select
`timescale 1ns/1ps
`default_nettype none
module shbp_host_model (
   input wire logic clk_sys,
   input wire logic pol,
   input wire logic hold_off_n,
   input wire logic [15:0] dataOut,
   output logic chip_select_n,
   output logic mem_reg_select,
   output logic [17:0] device_address,
   output logic low_byte_read_n,
   output logic high_byte_read_n,
   output logic low_byte_write_n,
   output logic high_byte_write_n,
   output logic [15:0] dataIn
);
   initial begin
      {chip_select_n, low_byte_read_n, high_byte_read_n} = 3'h7;
      {low_byte_write_n, high_byte_write_n, mem_reg_select} = 3'h6;
      device_address = 18'h0;
      dataIn = 16'h0;
   end
   // ----------
   // One access
   // ----------
   task automatic access(input logic mem, input logic [17:0] a, input logic wr,
         input logic [1:0] be, input logic [15:0] wd, output logic [15:0] rd,
         output int n, output logic ok);
      n = 0;
      ok = 1'b0;
      @(posedge clk_sys);
      // Select with address, no delay, normal timing, slave ends cycle
      chip_select_n <= 1'b0;
      mem_reg_select <= mem;
      device_address <= a;
      low_byte_write_n <= !(wr && be[0]);
      high_byte_write_n <= !(wr && be[1]);
      // Direction carried by read or write strobes, 16-bit port size
      low_byte_read_n <= wr;
      high_byte_read_n <= wr;
      dataIn <= wr ? wd : ~dataIn;
      while (n >= 0) begin
         @(posedge clk_sys);
         #1;
         n++;
         if (hold_off_n === pol) break;
         if (n > 40) n = -1;
      end
      rd = dataOut;
      // Strobes held one cycle past the acknowledge
      @(posedge clk_sys);
      #1;
      ok = (n > 0) && (hold_off_n !== pol);
      @(posedge clk_sys);
      {chip_select_n, low_byte_read_n, high_byte_read_n} <= 3'h7;
      {low_byte_write_n, high_byte_write_n} <= 2'h3;
      device_address <= ~device_address;
      dataIn <= ~dataIn;
   endtask
endmodule // shbp_host_model
`default_nettype wire

// >>> shbp_port16_tb_top.sv
// Testbench for the device end of the host bus port
`timescale 1ns/1ps
`default_nettype none
module shbp_port16_tb_top;
   logic clk_sys, reset_n, pol, endianStrap, rspReady, busy, ok, chip_select_n, mem_reg_select;
   logic low_byte_read_n, high_byte_read_n, low_byte_write_n, high_byte_write_n;
   logic dataOutEn_n, hold_off_n, holdOffEn_n, bigEndian, reqValid;
   logic [2:0] modeStrap;
   logic [3:0] busMode;
   logic [17:0] device_address;
   logic [15:0] rspData, rd, dataIn, dataOut;
   shbp_pkg::shbp_req_s reqOut, lastReq;
   int num_errors = 0, compares = 0, reqCnt = 0, n, nFast, arbDelay, dly;
   shbp_port16 dut (.clk_sys, .reset_n, .chip_select_n, .mem_reg_select, .device_address,
      .low_byte_read_n, .high_byte_read_n, .low_byte_write_n, .high_byte_write_n,
      // Transfer begin is not routed to the device, so bus start is tied high
      .bus_start_n(1'b1), .dataIn, .dataOut, .dataOutEn_n, .hold_off_n, .holdOffEn_n,
      .endian_strap(endianStrap), .hold_polarity_strap(pol), .modeStrap, .busMode,
      .bigEndian, .reqValid, .reqOut, .rspReady, .rspData);
   shbp_host_model host (.clk_sys, .pol, .hold_off_n, .dataOut, .chip_select_n,
      .mem_reg_select, .device_address, .low_byte_read_n, .high_byte_read_n,
      .low_byte_write_n, .high_byte_write_n, .dataIn);
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // ----------
   // Arbiter side
   // ----------
   always @(posedge clk_sys) begin
      if (reqValid === 1'b1) begin
         lastReq <= reqOut;
         reqCnt <= reqCnt + 1;
         dly <= arbDelay;
         busy <= 1'b1;
      end else if (!reset_n || hold_off_n === pol) begin
         busy <= 1'b0;
         rspReady <= 1'b0;
      end else if (busy) begin
         if (dly == 0) begin
            rspReady <= 1'b1;
            busy <= 1'b0;
         end else dly <= dly - 1;
      end
   end
   // ----------
   // Checks
   // ----------
   task check(input logic [39:0] seen, input logic [39:0] exp, input string msg);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   task close_out;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task acc(input logic mem, input logic [17:0] a, input logic wr, input logic [1:0] be,
         input logic [15:0] wd);
      host.access(mem, a, wr, be, wd, rd, n, ok);
      if (n < 0) begin
         num_errors++;
         close_out;
      end
      @(posedge clk_sys);
      #1;
      check(ok, 1'b1, "hold pulse length");
      check(n >= 2, 1'b1, "cycle too short");
      check(holdOffEn_n, 1'b1, "hold driven while deselected");
      check({lastReq.memSpace, lastReq.addr, lastReq.isWrite, lastReq.byteEn},
         {mem, a, wr, wr ? be : 2'b11}, "request fields");
      if (wr) check(lastReq.wdata, wd, "write data");
      else check(rd, rspData, "read data");
   endtask
   // ----------
   // Sequence
   // ----------
   initial begin
      {reset_n, pol, endianStrap, modeStrap} = 6'h1b;
      rspData = 16'h5aa5;
      arbDelay = 0;
      @(posedge clk_sys);
      #1 check({hold_off_n, holdOffEn_n, dataOutEn_n}, 3'b011, "reset outputs");
      @(posedge clk_sys);
      reset_n <= 1'b1;
      endianStrap <= 1'b0;
      modeStrap <= 3'b100;
      repeat (2) @(posedge clk_sys);
      #1 check({busMode, bigEndian}, 5'h17, "strap latch");
      for (int i = 0; i < 6; i++) acc(i[0], 18'(18'h3fffe - i), 1'b1, 2'(i % 3 + 1),
         16'(16'ha5c3 ^ i * 16'h1111));
      acc(1'b0, 18'h00002, 1'b0, 2'b11, 16'h0);
      nFast = n;
      arbDelay = 3;
      rspData = 16'hc33c;
      acc(1'b1, 18'h1fffe, 1'b0, 2'b11, 16'h0);
      check(n === nFast + 3, 1'b1, "stall length");
      check(reqCnt, 8, "request count");
      @(posedge clk_sys);
      reset_n <= 1'b0;
      pol <= 1'b0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 check({busMode, bigEndian}, 5'h08, "strap relatch");
      acc(1'b0, 18'h00010, 1'b0, 2'b11, 16'h0);
      close_out;
   end
endmodule // shbp_port16_tb_top
`default_nettype wire
